// ---- rtl/pcacc_params.svh ----
// constants of the power calculation and averaging engine
// Functional notes
// RULE_01 - current and power computed only after shunt and bus samples both arrived
// RULE_02 - power multiplies previously computed current with latest bus sample
// RULE_03 - zero shunt calibration forces reported power to zero
// RULE_04 - with averaging above one, per-sample results stay in the accumulator
// RULE_05 - each sample's current and power are added until count reached
// RULE_06 - averaged current and power load into outputs in one update
// RULE_07 - arithmetic runs beside conversion and never stalls the sequencer
// RULE_08 - shunt, bus and temperature samples arrive one at a time
// RULE_09 - serial port works with chip select held low permanently
// RULE_10 - averaging count programmable from 1 up to 1024 samples
// RULE_11 - one averaging count applies to every enabled input
// RULE_12 - accumulator cleared at the start of every averaging block
`ifndef PCACC_PARAMS_SVH
`define PCACC_PARAMS_SVH
`define PCACC_SAMPLE_W 16
`define PCACC_CAL_W 15
`define PCACC_CUR_W 16
`define PCACC_PWR_W 24
`define PCACC_AVG_SEL_W 3
`define PCACC_ACC_W 34
`define PCACC_CNT_W 11
`define PCACC_SHIFT_W 4
`endif

// ---- rtl/pcacc_pkg.sv ----
// types of the power calculation engine
`default_nettype none
`include "pcacc_params.svh"
package pcacc_pkg;
   typedef enum logic [3:0] {
      PCACC_IDLE = 4'h1,
      PCACC_CUR = 4'h2,
      PCACC_PWR = 4'h4,
      PCACC_ACC = 4'h8
   } pcacc_state_t;
   typedef enum logic [1:0] {
      PCACC_CH_SHUNT = 2'h0,
      PCACC_CH_BUS = 2'h1,
      PCACC_CH_TEMP = 2'h2
   } pcacc_chan_t;
endpackage
`default_nettype wire

// ---- rtl/pcacc_mult.sv ----
// registered signed by unsigned multiplier with truncating right shift
`default_nettype none
`include "pcacc_params.svh"
module pcacc_mult #(
   parameter int AW = 16,
   parameter int BW = 16,
   parameter int PW = 24,
   parameter int SH = 0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // operands
   input wire logic signed [AW-1:0] a,
   input wire logic [BW-1:0] b,
   // product
   output logic signed [PW-1:0] p
);
   wire logic signed [AW+BW:0] prod;
   assign prod = a * $signed({1'b0, b});
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         p <= '0;
      end else begin
         p <= PW'(prod >>> SH);
      end
   end
endmodule // pcacc_mult

// ---- rtl/pcacc_engine.sv ----
// background current and power calculation with sample averaging
`default_nettype none
`include "pcacc_params.svh"
module pcacc_engine (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire logic [`PCACC_AVG_SEL_W-1:0] avg_sel,
   input wire logic [`PCACC_CAL_W-1:0] shunt_cal,
   input wire logic restart,
   // converter samples, one per pulse
   input wire logic smp_vld,
   input wire logic [1:0] smp_chan,
   input wire logic signed [`PCACC_SAMPLE_W-1:0] smp_data,
   // results
   output logic signed [`PCACC_CUR_W-1:0] current_r,
   output logic [`PCACC_PWR_W-1:0] power_r,
   output logic result_upd_r
);
   // ****************************************
   // decoding
   // ****************************************
   function automatic logic [`PCACC_SHIFT_W-1:0] avg_shift(input logic [2:0] sel);
      unique case (sel)
         3'h0: avg_shift = 4'h0;
         3'h1: avg_shift = 4'h2;
         3'h2: avg_shift = 4'h4;
         3'h3: avg_shift = 4'h6;
         3'h4: avg_shift = 4'h7;
         3'h5: avg_shift = 4'h8;
         3'h6: avg_shift = 4'h9;
         default: avg_shift = 4'ha;
      endcase
   endfunction

   wire logic [`PCACC_SHIFT_W-1:0] shift;
   wire logic [`PCACC_CNT_W-1:0] n_avg;
   wire logic shunt_in, bus_in;
   wire logic go;
   pcacc_pkg::pcacc_state_t st_r, st_nxt;
   assign shift = avg_shift(avg_sel); // see RULE_10 see RULE_11
   assign n_avg = `PCACC_CNT_W'(1) << shift;
   // samples come one at a time from a single converter
   assign shunt_in = smp_vld && (smp_chan == pcacc_pkg::PCACC_CH_SHUNT); // see RULE_08
   assign bus_in = smp_vld && (smp_chan == pcacc_pkg::PCACC_CH_BUS); // see RULE_08

   // ****************************************
   // sample capture
   // ****************************************
   logic signed [`PCACC_SAMPLE_W-1:0] shunt_r;
   logic [`PCACC_SAMPLE_W-1:0] bus_r;
   logic have_shunt_r, have_bus_r;
   // a sample landing during a pass is kept for the next pass
   always_ff @(posedge clk) begin
      if (!rst_n || restart) begin
         shunt_r <= '0;
         bus_r <= '0;
         have_shunt_r <= 1'b0;
         have_bus_r <= 1'b0;
      end else begin
         if (shunt_in) begin
            shunt_r <= smp_data;
         end
         if (bus_in) begin
            bus_r <= smp_data[`PCACC_SAMPLE_W-1:0];
         end
         have_shunt_r <= shunt_in ? 1'b1 : (go ? 1'b0 : have_shunt_r);
         have_bus_r <= bus_in ? 1'b1 : (go ? 1'b0 : have_bus_r);
      end
   end
   // wait for both samples of the present cycle
   assign go = have_shunt_r && have_bus_r && (st_r == pcacc_pkg::PCACC_IDLE); // see RULE_01

   // ****************************************
   // arithmetic pipeline
   // ****************************************
   // both multipliers run every cycle; the state machine only picks when to take them
   logic signed [`PCACC_CUR_W-1:0] cur_calc;
   logic signed [`PCACC_PWR_W-1:0] pwr_calc;
   logic signed [`PCACC_CUR_W-1:0] cur_prev_r;
   pcacc_mult #(.AW(`PCACC_SAMPLE_W), .BW(`PCACC_CAL_W), .PW(`PCACC_CUR_W), .SH(11)) u_cur (
      .clk(clk),
      .rst_n(rst_n),
      .a(shunt_r),
      .b(shunt_cal),
      .p(cur_calc)
   );
   // power uses the current from the previous step and the newest bus sample
   pcacc_mult #(.AW(`PCACC_CUR_W), .BW(`PCACC_SAMPLE_W), .PW(`PCACC_PWR_W), .SH(4)) u_pwr (
      .clk(clk),
      .rst_n(rst_n),
      .a(cur_prev_r),
      .b(bus_r),
      .p(pwr_calc)
   ); // see RULE_02

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         pcacc_pkg::PCACC_IDLE: begin
            if (go) begin
               st_nxt = pcacc_pkg::PCACC_CUR;
            end
         end
         pcacc_pkg::PCACC_CUR: begin
            st_nxt = pcacc_pkg::PCACC_PWR;
         end
         pcacc_pkg::PCACC_PWR: begin
            st_nxt = pcacc_pkg::PCACC_ACC;
         end
         pcacc_pkg::PCACC_ACC: begin
            st_nxt = pcacc_pkg::PCACC_IDLE;
         end
         default: begin
            st_nxt = pcacc_pkg::PCACC_IDLE;
         end
      endcase
   end

   // ****************************************
   // accumulation and output update
   // ****************************************
   logic signed [`PCACC_ACC_W-1:0] acc_cur_r;
   logic [`PCACC_ACC_W-1:0] acc_pwr_r;
   logic [`PCACC_CNT_W-1:0] cnt_r;
   wire logic acc_step, last;
   wire logic signed [`PCACC_ACC_W-1:0] cur_sum;
   wire logic [`PCACC_ACC_W-1:0] pwr_sum;
   wire logic [`PCACC_PWR_W-1:0] pwr_abs;
   assign acc_step = (st_r == pcacc_pkg::PCACC_ACC);
   // sign dropped: reported power is a magnitude
   assign pwr_abs = pwr_calc[`PCACC_PWR_W-1] ? `PCACC_PWR_W'(-pwr_calc) : pwr_calc;
   // first sample of a block overwrites, so nothing from the last block carries
   assign cur_sum = (cnt_r == '0 ? '0 : acc_cur_r) + `PCACC_ACC_W'(cur_calc); // see RULE_12
   assign pwr_sum = (cnt_r == '0 ? '0 : acc_pwr_r) + `PCACC_ACC_W'(pwr_abs); // see RULE_05
   // lowering avg_sel inside a block needs restart, else the count overshoots its end
   assign last = (cnt_r + `PCACC_CNT_W'(1)) == n_avg; // see RULE_04

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= pcacc_pkg::PCACC_IDLE;
         cur_prev_r <= '0;
      end else begin
         st_r <= restart ? pcacc_pkg::PCACC_IDLE : st_nxt;
         if (st_r == pcacc_pkg::PCACC_PWR) begin
            cur_prev_r <= cur_calc;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || restart) begin
         acc_cur_r <= '0;
         acc_pwr_r <= '0;
         cnt_r <= '0;
      end else if (acc_step) begin
         acc_cur_r <= cur_sum; // see RULE_05
         acc_pwr_r <= pwr_sum;
         cnt_r <= last ? '0 : cnt_r + `PCACC_CNT_W'(1); // see RULE_12
      end
   end

   // independent of conversion: sequencer is never stalled
   // results stand until the next block end, so an unframed read is always valid
   always_ff @(posedge clk) begin // see RULE_09
      if (!rst_n) begin
         current_r <= '0;
         power_r <= '0;
         result_upd_r <= 1'b0;
      end else begin
         result_upd_r <= acc_step && last; // see RULE_07
         if (acc_step && last) begin
            current_r <= `PCACC_CUR_W'(cur_sum >>> shift); // see RULE_06
            power_r <= (shunt_cal == '0) ? '0 : `PCACC_PWR_W'(pwr_sum >> shift); // see RULE_03
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_calc;
      go ##1 (st_r == pcacc_pkg::PCACC_CUR) ##1 (st_r == pcacc_pkg::PCACC_PWR);
   endsequence
   a_calc_needs_both: assert property (@(posedge clk) // see RULE_01
      disable iff (!rst_n || restart)
      $rose(st_r == pcacc_pkg::PCACC_CUR) |-> $past(have_shunt_r && have_bus_r))
      else $error("calc started without both samples");
   a_calc_walk: assert property (@(posedge clk) disable iff (!rst_n || restart) // see RULE_07
      s_calc |-> ##1 acc_step)
      else $error("calc sequence broken");
   a_power_zero_cal: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_03
      (result_upd_r && $past(shunt_cal) == '0) |-> power_r == '0)
      else $error("power not zero with zero calibration");
   a_single_update: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_06
      result_upd_r |=> !result_upd_r)
      else $error("output updated twice in a row");
   a_hold_between: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
      !result_upd_r && !$past(acc_step && last) |-> $stable(current_r))
      else $error("current changed outside block end");
   a_count_bound: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_10
      cnt_r < n_avg || $changed(avg_sel))
      else $error("sample count exceeds averaging count");
   a_temp_ignored: assert property (@(posedge clk) disable iff (!rst_n || restart) // see RULE_08
      (smp_vld && smp_chan == pcacc_pkg::PCACC_CH_TEMP) |=> $stable(shunt_r) && $stable(bus_r))
      else $error("temperature sample disturbed shunt or bus capture");
   a_block_clear: assert property (@(posedge clk) disable iff (!rst_n || restart) // see RULE_12
      (acc_step && last) |=> cnt_r == '0)
      else $error("counter not cleared at block end");
   a_power_hold: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
      (acc_step && !last) |=> $stable(power_r) && !result_upd_r)
      else $error("power changed inside an averaging block");
   a_go_clears: assert property (@(posedge clk) disable iff (!rst_n || restart) // see RULE_01
      (go && !shunt_in && !bus_in) |=> !have_shunt_r && !have_bus_r)
      else $error("sample flags not cleared after calc start");
   a_upd_source: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_06
      result_upd_r |-> $past(acc_step && last))
      else $error("output update without block end");
   a_block_restart: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
      restart |=> (cnt_r == '0) && !have_shunt_r && !have_bus_r
      && (st_r == pcacc_pkg::PCACC_IDLE))
      else $error("restart did not clear the block state");
endmodule // pcacc_engine
`default_nettype wire

// ---- tb/pcacc_seq_model.sv ----
// sequencer model: shunt, bus and temperature samples one at a time
`default_nettype none
`include "pcacc_params.svh"
module pcacc_seq_model (
   // clock and command
   input wire logic clk,
   input wire logic go,
   input wire logic signed [`PCACC_SAMPLE_W-1:0] shunt,
   input wire logic signed [`PCACC_SAMPLE_W-1:0] bus,
   // samples
   output logic smp_vld,
   output logic [1:0] smp_chan,
   output logic signed [`PCACC_SAMPLE_W-1:0] smp_data,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ps;
   // one pulse, then data shows junk so a late capture cannot pass
   task automatic send(input logic [1:0] ch, input logic [`PCACC_SAMPLE_W-1:0] d);
      smp_vld <= 1'b1;
      smp_chan <= ch;
      smp_data <= d;
      @(posedge clk);
      smp_vld <= 1'b0;
      smp_data <= ~d;
      repeat (5) @(posedge clk);
   endtask
   initial begin
      smp_vld = 1'b0;
      smp_chan = 2'h0;
      smp_data = 16'h0;
      done = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            send(pcacc_pkg::PCACC_CH_SHUNT, shunt);
            send(pcacc_pkg::PCACC_CH_BUS, bus);
            send(pcacc_pkg::PCACC_CH_TEMP, 16'h7ff0);
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
         end
      end
   end
endmodule // pcacc_seq_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench of the power calculation engine
`default_nettype none
`include "pcacc_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] avg_sel = 3'h0;
   logic [14:0] shunt_cal = 15'h0800;
   logic restart = 1'b0;
   logic go = 1'b0;
   logic signed [15:0] shunt = 16'h0;
   logic signed [15:0] bus = 16'h0;
   wire logic smp_vld, done;
   wire logic [1:0] smp_chan;
   wire logic signed [15:0] smp_data, current_r;
   wire logic [23:0] power_r;
   wire logic result_upd_r;
   int num_errors = 0;
   int num_checks = 0;
   int n_upd = 0;
   int base;
   pcacc_engine dut_u (.clk(clk), .rst_n(rst_n), .avg_sel(avg_sel), .shunt_cal(shunt_cal),
      .restart(restart), .smp_vld(smp_vld), .smp_chan(smp_chan), .smp_data(smp_data),
      .current_r(current_r), .power_r(power_r), .result_upd_r(result_upd_r));
   pcacc_seq_model seq_u (.clk(clk), .go(go), .shunt(shunt), .bus(bus), .smp_vld(smp_vld),
      .smp_chan(smp_chan), .smp_data(smp_data), .done(done));
   initial forever #4 clk = ~clk;
   always @(posedge clk) if (result_upd_r === 1'b1) n_upd <= n_upd + 1;
   task automatic test_done();
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one shunt plus bus step; the model also sends a temperature sample
   task automatic step(input logic signed [15:0] sh, input logic signed [15:0] bu);
      int i;
      @(posedge clk);
      shunt <= sh;
      bus <= bu;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk);
      if (i == 100) begin
         num_errors++;
         test_done();
      end
   endtask
   task automatic setup(input logic [2:0] sel, input logic [14:0] cal);
      @(posedge clk);
      avg_sel <= sel;
      shunt_cal <= cal;
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      base = n_upd;
   endtask
   task automatic scen_single();
      setup(3'h0, 15'h0800);
      step(16'sd1000, 16'sd100);
      step(16'sd1000, 16'sd100);
      repeat (10) @(posedge clk);
      check("current", 32'(current_r), 32'h3e8);
      check("power", 32'(power_r), 32'h186a);
      check("updates", 32'(n_upd - base), 32'h2);
   endtask
   task automatic scen_avg4();
      setup(3'h1, 15'h0800);
      for (int k = 1; k <= 4; k++) step(16'(1000 * k), 16'sd100);
      repeat (10) @(posedge clk);
      check("avg current", 32'(current_r), 32'h9c4);
      check("avg updates", 32'(n_upd - base), 32'h1);
      check("avg power", 32'(power_r), 32'h2ab9);
      for (int k = 0; k < 2; k++) step(16'sd1000, 16'sd100);
      check("held current", 32'(current_r), 32'h9c4);
      check("held power", 32'(power_r), 32'h2ab9);
      for (int k = 0; k < 2; k++) step(16'sd1000, 16'sd100);
      repeat (10) @(posedge clk);
      check("next avg", 32'(current_r), 32'h3e8);
   endtask
   task automatic scen_cal0();
      setup(3'h0, 15'h0);
      step(16'sd1000, 16'sd100);
      check("zero cal first power", 32'(power_r), 32'h0);
      step(16'sd1000, 16'sd100);
      repeat (10) @(posedge clk);
      check("zero cal power", 32'(power_r), 32'h0);
   endtask
   task automatic scen_avg1024();
      setup(3'h7, 15'h0800);
      for (int k = 0; k < 1024; k++) step(16'sd1000, 16'sd200);
      repeat (10) @(posedge clk);
      check("max avg current", 32'(current_r), 32'h3e8);
      check("max avg power", 32'(power_r), 32'h30c7);
      check("max avg updates", 32'(n_upd - base), 32'h1);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("reset current", 32'(current_r), 32'h0);
      check("reset power", 32'(power_r), 32'h0);
      scen_single();
      scen_avg4();
      scen_cal0();
      scen_avg1024();
      test_done();
   end
endmodule // tb
`default_nettype wire
